// ==== core/arx_pkg.sv ====
package arx_pkg;
	// ********************
	// Register map
	// ********************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_WBCNT = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_1E00;
	localparam int CTRL_W = 13;
	localparam int STAT_CLR_NULL = 5;
	localparam int STAT_CLR_DD = 6;
	// ********************
	// Write-back layout
	// ********************
	localparam int W0_RSS = 0;
	localparam int W0_PTYPE = 4;
	localparam int W0_CNT = 17;
	localparam int W0_HLEN = 21;
	localparam int W0_SPH = 31;
	localparam int W0_ID = 32;
	localparam int W0_FCSUM = 48;
	localparam int PT_IPV6 = 2;
	localparam int PT_TCP = 4;
	localparam int PT_UDP = 5;
	localparam int PT_TUNNEL = 12;
	localparam logic [3:0] RSS_HASH_MIN = 4'h1;
	localparam logic [3:0] RSS_HASH_MAX = 4'h8;
	localparam logic [15:0] HDR_LIMIT = 16'h0400;
	localparam logic [9:0] HLEN_MAX = 10'h3FF;
	localparam logic [3:0] CNT_MAX = 4'hF;
	localparam logic [3:0] CNT_CLOSE = 4'hE;
	localparam logic [14:0] BUCKET_FULL = 15'h7FFF;
	localparam logic [3:0] BUCKET_BITS_MAX = 4'hF;
	// ********************
	// Carriers
	// ********************
	// First member is the top of the control word, so format select lands in bits 2:0
	typedef struct packed {
		logic [3:0] bucketBits;
		logic fdirPerfect;
		logic dblVlanEn;
		logic ipPayCsumEn;
		logic csumOffHash;
		logic cntBypass;
		logic vlanHide;
		logic [2:0] fmtSel;
	} arx_cfg_t;
	typedef struct packed {
		logic eop;
		logic coalesced;
		logic [3:0] rssType;
		logic [12:0] ptype;
		logic [6:0] innerL34;
		logic ipv4Frag;
		logic [15:0] hdrBytes;
		logic hdrFound;
		logic [31:0] hash;
		logic rssCalc;
		logic fdirMatch;
		logic [14:0] fdirBucket;
		logic [15:0] fdirSig;
		logic [15:0] fdirSwIdx;
		logic [15:0] fragCsum;
		logic vlanSeen;
		logic udp_checksum_done;
		logic tcpCs;
		logic sctpCrc;
		logic ipcs;
		logic pif;
		logic outerIpChk;
		logic outerVlan;
		logic udpFragCsum;
		logic tsip;
		logic ts;
		logic secp;
		logic lb;
		logic bmc;
		logic [15:0] nextPtr;
	} arx_evt_t;
endpackage : arx_pkg

// ==== core/arx_status_build.sv ====
`timescale 1ns/1ns
`default_nettype none
module arx_status_build import arx_pkg::*; (
	// Inputs
	input wire arx_evt_t evt,
	input wire arx_cfg_t cfg,
	// Result
	output logic [19:0] status
);
	always_comb begin
		status = 20'h0_0000;
		status[0] = 1'b1;
		status[1] = evt.eop;
		if (evt.eop) begin // see RL18
			status[2] = evt.fdirMatch; // see RL17
			status[3] = evt.vlanSeen & ~cfg.vlanHide; // see RL19
			status[4] = evt.udp_checksum_done; // see RL20
			status[5] = evt.udp_checksum_done | evt.tcpCs | evt.sctpCrc; // see RL20
			status[6] = evt.ipcs;
			status[7] = evt.pif;
			status[8] = evt.outerIpChk; // see RL21
			status[9] = evt.outerVlan & cfg.dblVlanEn; // see RL21
			status[10] = evt.udpFragCsum & evt.ipv4Frag & ~evt.ptype[PT_TUNNEL]; // see RL22
			status[15] = evt.tsip;
			status[16] = evt.ts;
			status[17] = evt.secp;
			status[18] = evt.lb;
			status[19] = evt.bmc;
		end else begin
			status[19:4] = evt.nextPtr; // see RL18
		end
	end
endmodule : arx_status_build
`default_nettype wire

// ==== core/arx_word0_build.sv ====
`timescale 1ns/1ns
`default_nettype none
module arx_word0_build import arx_pkg::*; (
	// Inputs
	input wire arx_evt_t evt,
	input wire arx_cfg_t cfg,
	input wire logic first,
	input wire logic [3:0] starts,
	// Result
	output logic [63:0] word0
);
	logic [12:0] pt;
	logic [14:0] mask;
	logic fragSlot;
	always_comb begin
		pt = evt.ptype;
		if (evt.ptype[PT_TUNNEL])
			pt[6:0] = evt.innerL34; // see RL9
		if (evt.ipv4Frag) begin // see RL8
			pt[PT_UDP] = 1'b0;
			pt[PT_TCP] = 1'b0;
			pt[PT_IPV6] = 1'b0;
		end
		mask = BUCKET_FULL >> (BUCKET_BITS_MAX - cfg.bucketBits); // see RL16
		fragSlot = evt.ipv4Frag & evt.ptype[PT_UDP] & cfg.ipPayCsumEn
			& (~cfg.csumOffHash | ~evt.rssCalc);
		word0 = 64'h0;
		word0[W0_RSS +: 4] = evt.rssType; // see RL7
		word0[W0_PTYPE +: 13] = pt; // see RL8
		if (evt.coalesced) // see RL10
			word0[W0_CNT +: 4] = (starts == CNT_MAX) ? CNT_MAX : starts + 4'h1; // see RL11
		if (first) // see RL12
			word0[W0_HLEN +: 10] = (evt.hdrBytes >= HDR_LIMIT) ? HLEN_MAX : evt.hdrBytes[9:0];
		word0[W0_SPH] = evt.eop & evt.hdrFound & (evt.hdrBytes < HDR_LIMIT); // see RL13
		if (fragSlot) begin
			word0[W0_FCSUM +: 16] = evt.fragCsum; // see RL14
		end else if (evt.fdirMatch && cfg.fdirPerfect) begin
			word0[W0_ID +: 16] = evt.fdirSwIdx; // see RL17
		end else if (evt.fdirMatch) begin
			word0[W0_ID +: 15] = evt.fdirBucket & mask; // see RL16
			word0[W0_FCSUM +: 16] = evt.fdirSig;
		end else if (evt.rssType >= RSS_HASH_MIN && evt.rssType <= RSS_HASH_MAX) begin
			word0[W0_ID +: 32] = evt.hash; // see RL15
		end
	end
endmodule : arx_word0_build
`default_nettype wire

// ==== core/arx_desc_format.sv ====
// Summary of operation
// RL1: Software sets format select non-zero for advanced.
// RL2: Non-zero format select gives advanced write-back.
// RL3: Read descriptor: packet and header addresses, done bit.
// RL4: Header buffer used in first descriptor only.
// RL5: Software clears done bit; header addresses aligned.
// RL6: Software never supplies zero buffer addresses.
// RL7: Four-bit RSS type at bit 0.
// RL8: Packet type at bit 4; fragments drop L4/IPv6.
// RL9: Tunnel packets report inner L3/L4 indications.
// RL10: Coalesce count zero, else one plus starts.
// RL11: Bypass lets coalescing continue; count saturates.
// RL12: Header length at bit 21, first descriptor only.
// RL13: Header split flag bit 31, below 1024, EOP.
// RL14: Fragment checksum at bit 48 when enabled.
// RL15: Hash meaningful only for RSS types 1-8.
// RL16: Bucket hash masked to filter table size.
// RL17: Filter match status bit 2 qualifies index.
// RL18: Status layout depends on end of packet.
// RL19: VLAN bit cleared when VLAN hiding enabled.
// RL20: UDP checksum bit 4; any L4 bit 5.
// RL21: Outer IP checksum bit 8; outer VLAN 9.
// RL22: Bit 10 marks fragment UDP checksum computed.
// RL23: Software polls done flag, not head pointer.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module arx_desc_format import arx_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clkEn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Read descriptors from fetch
	input wire logic descValid,
	output logic descReady,
	input wire logic [63:0] pktAddr,
	input wire logic [63:0] hdrAddr,
	// Buffer completion events
	input wire logic evtValid,
	output logic evtReady,
	input wire arx_evt_t evt,
	input wire logic pktStart,
	// Buffer addresses for the data mover
	output logic bufValid,
	output logic [63:0] dataAddr,
	output logic hdrAddrValid,
	output logic [63:0] hdrAddrOut,
	output logic coalesceClose,
	// Write-back descriptors
	output logic wbValid,
	input wire logic wbReady,
	output logic wbAdvanced,
	output logic [63:0] wbWord0,
	output logic [63:0] wbWord1
);
	// ********************
	// State
	// ********************
	typedef struct packed {
		arx_cfg_t cfg;
		logic busPend;
		logic busWrite;
		logic [7:0] busAddr;
		logic [31:0] rdata;
		logic held;
		logic [63:0] pkt;
		logic [63:0] hdr;
		logic first;
		logic [3:0] starts;
		logic nullSeen;
		logic ddSeen;
		logic [15:0] wbCount;
		logic wbv;
		logic wbAdv;
		logic [63:0] w0;
		logic [63:0] w1;
	} arx_state_t;

	arx_state_t st;
	arx_state_t next_st;
	logic [63:0] word0;
	logic [19:0] status;
	logic addrPhase;
	logic takeDesc;
	logic takeEvt;
	logic [31:0] readVal;

	// ********************
	// Field builders
	// ********************
	arx_word0_build uWord0 (
		.evt(evt),
		.cfg(st.cfg),
		.first(st.first),
		.starts(st.starts),
		.word0(word0)
	);

	arx_status_build uStatus (
		.evt(evt),
		.cfg(st.cfg),
		.status(status)
	);

	// ********************
	// Handshakes
	// ********************
	// Zero wait states: every access completes in its data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st.rdata;
	assign addrPhase = hsel & htrans[1] & hready;
	// One descriptor at a time; the next waits until this one's completion event is taken
	assign descReady = clkEn & ~st.held;
	// A full write-back slot stalls completions until the host side drains it
	assign evtReady = clkEn & st.held & (~st.wbv | wbReady);
	assign takeDesc = descValid & descReady;
	assign takeEvt = evtValid & evtReady;
	assign bufValid = st.held;
	assign dataAddr = st.pkt;
	assign hdrAddrValid = st.held & st.first; // see RL4
	assign hdrAddrOut = {st.hdr[63:1], 1'b0}; // see RL3
	assign coalesceClose = st.held & (st.starts >= CNT_CLOSE) & ~st.cfg.cntBypass; // see RL10
	assign wbValid = st.wbv;
	assign wbAdvanced = st.wbAdv;
	assign wbWord0 = st.w0;
	assign wbWord1 = st.w1;

	// ********************
	// Register read mux
	// ********************
	always_comb begin
		readVal = 32'h0000_0000;
		case (haddr[7:0])
			ADDR_CTRL: readVal[CTRL_W-1:0] = st.cfg;
			ADDR_STAT: begin
				readVal[0] = st.held;
				readVal[4:1] = st.starts;
				readVal[STAT_CLR_NULL] = st.nullSeen;
				readVal[STAT_CLR_DD] = st.ddSeen;
				readVal[7] = st.first;
				readVal[8] = st.wbv;
			end
			ADDR_WBCNT: readVal[15:0] = st.wbCount;
			default: readVal = 32'h0000_0000;
		endcase
	end

	// ********************
	// Next state
	// ********************
	always_comb begin
		next_st = st;
		// Bus: address captured, data phase applies the write
		next_st.busPend = addrPhase;
		if (addrPhase) begin
			next_st.busWrite = hwrite;
			next_st.busAddr = haddr[7:0];
			next_st.rdata = hwrite ? 32'h0000_0000 : readVal;
		end
		if (st.busPend && st.busWrite) begin
			case (st.busAddr)
				ADDR_CTRL: next_st.cfg = hwdata[CTRL_W-1:0];
				ADDR_STAT: begin
					// Write one to clear the sticky flags
					if (hwdata[STAT_CLR_NULL])
						next_st.nullSeen = 1'b0;
					if (hwdata[STAT_CLR_DD])
						next_st.ddSeen = 1'b0;
				end
				default: next_st.cfg = st.cfg;
			endcase
		end
		// Descriptor intake; flags are set after the clear so a new event wins
		if (takeDesc) begin
			next_st.held = 1'b1;
			next_st.pkt = pktAddr;
			next_st.hdr = hdrAddr;
			next_st.starts = 4'h0;
			if (pktAddr == 64'h0 || hdrAddr == 64'h0)
				next_st.nullSeen = 1'b1; // see RL6
			if (hdrAddr[0])
				next_st.ddSeen = 1'b1; // see RL5
		end
		// Packets starting in the current buffer; count saturates
		if (st.held && pktStart && st.starts != CNT_MAX)
			next_st.starts = st.starts + 4'h1; // see RL11
		// Drain of write-back slot
		if (st.wbv && wbReady)
			next_st.wbv = 1'b0;
		// Buffer completion builds the write-back
		if (takeEvt) begin
			next_st.held = 1'b0;
			next_st.wbv = 1'b1;
			next_st.wbCount = st.wbCount + 16'h0001;
			next_st.first = evt.eop; // see RL4
			next_st.wbAdv = (st.cfg.fmtSel != 3'b000); // see RL2
			if (st.cfg.fmtSel != 3'b000) begin
				next_st.w0 = word0;
				next_st.w1 = {44'h0, status}; // see RL18
			end else begin
				// Legacy layout is handled elsewhere; only done and end flags
				next_st.w0 = 64'h0;
				next_st.w1 = {62'h0, evt.eop, 1'b1};
			end
		end
	end

	// ********************
	// State register
	// ********************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.cfg <= CTRL_RESET[CTRL_W-1:0];
			st.first <= 1'b1;
		end else if (clkEn) begin
			st <= next_st;
		end
	end
endmodule : arx_desc_format
`default_nettype wire

// ==== dv/arx_desc_format_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module arx_chk import arx_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Watched ports
	input wire logic descValid,
	input wire logic descReady,
	input wire logic [63:0] pktAddr,
	input wire logic bufValid,
	input wire logic [63:0] dataAddr,
	input wire logic hdrAddrValid,
	input wire logic [63:0] hdrAddrOut,
	input wire logic evtValid,
	input wire logic evtReady,
	input wire arx_evt_t evt,
	input wire logic wbValid,
	input wire logic wbReady,
	input wire logic wbAdvanced,
	input wire logic [63:0] wbWord0,
	input wire logic [63:0] wbWord1
);
	// ****
	// Checks
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic take;
	assign take = evtValid && evtReady;
	desc_take_a: assert property (
		descValid && descReady |=> bufValid && dataAddr == $past(pktAddr)) else $error("bad hold");
	desc_hold_a: assert property (
		bufValid |-> !descReady) else $error("second descriptor taken");
	hdr_align_a: assert property (
		hdrAddrValid |-> bufValid && !hdrAddrOut[0]) else $error("bad header address");
	wb_next_a: assert property (
		take |=> wbValid) else $error("no write-back");
	wb_stand_a: assert property (
		wbValid && !wbReady |=> wbValid && $stable(wbWord1)) else $error("write-back dropped");
	rss_type_a: assert property (
		take |=> !wbAdvanced || wbWord0[3:0] == $past(evt.rssType)) else $error("bad rss type");
	frag_l4_a: assert property (
		take && evt.ipv4Frag |=> !wbAdvanced || wbWord0[9:8] == 2'h0 && !wbWord0[6])
		else $error("fragment l4 set");
	cnt_zero_a: assert property (
		take && !evt.coalesced |=> !wbAdvanced || wbWord0[20:17] == 4'h0) else $error("bad count");
	sph_big_a: assert property (
		take && evt.hdrBytes >= HDR_LIMIT |=> !wbAdvanced || !wbWord0[W0_SPH]) else $error("bad split");
	next_ptr_a: assert property (
		take && !evt.eop |=> !wbAdvanced || wbWord1[19:4] == $past(evt.nextPtr))
		else $error("bad next pointer");
	fdir_flag_a: assert property (
		take && evt.eop && evt.fdirMatch |=> !wbAdvanced || wbWord1[2]) else $error("no match flag");
endmodule : arx_chk
`default_nettype wire

// ==== dv/arx_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module arx_host_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Descriptor offer
	output logic descValid,
	input wire logic descReady,
	output logic [63:0] pktAddr,
	output logic [63:0] hdrAddr,
	// Write-back
	input wire logic wbValid,
	output logic wbReady,
	input wire logic [63:0] wbWord0,
	input wire logic [63:0] wbWord1,
	output logic [63:0] gotW0,
	output logic [63:0] gotW1,
	output logic [7:0] gotCount
);
	// ****
	// Host side
	// ****
	// Ready toggles every cycle, so a write-back sees a stall first only when it lands on a low phase
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			descValid <= 1'h0;
			pktAddr <= 64'h0000_0001_0000_0000;
			hdrAddr <= 64'h0000_0002_0000_0000;
			wbReady <= 1'h0;
			gotCount <= 8'h00;
		end else begin
			descValid <= 1'h1;
			wbReady <= ~wbReady;
			if (descValid && descReady) begin
				pktAddr <= pktAddr + 64'h800;
				hdrAddr <= hdrAddr + 64'h40;
			end
			if (wbValid && wbReady) begin
				gotW0 <= wbWord0;
				gotW1 <= wbWord1;
				gotCount <= gotCount + 8'h01;
			end
		end
	end
endmodule : arx_host_model
`default_nettype wire

// ==== dv/tb_arx_desc_format.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_arx_desc_format import arx_pkg::*; ;
	logic clk_sys = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, evtValid = 1'h0;
	logic pktStart = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic hreadyout, hresp, descValid, descReady, bufValid, hdrAddrValid, coalesceClose;
	logic evtReady, wbValid, wbReady, wbAdvanced;
	logic [63:0] pktAddr, hdrAddr, dataAddr, hdrAddrOut, wbWord0, wbWord1, gotW0, gotW1;
	logic [7:0] gotCount;
	arx_evt_t evt = '0, e;
	int n_fail = 0, compares = 0;
	arx_desc_format u_arx_desc_format (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(1'h1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .descValid(descValid), .descReady(descReady), .pktAddr(pktAddr),
		.hdrAddr(hdrAddr), .evtValid(evtValid), .evtReady(evtReady), .evt(evt),
		.pktStart(pktStart), .bufValid(bufValid), .dataAddr(dataAddr),
		.hdrAddrValid(hdrAddrValid), .hdrAddrOut(hdrAddrOut), .coalesceClose(coalesceClose),
		.wbValid(wbValid), .wbReady(wbReady), .wbAdvanced(wbAdvanced), .wbWord0(wbWord0),
		.wbWord1(wbWord1));
	arx_host_model u_arx_host_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.descValid(descValid), .descReady(descReady), .pktAddr(pktAddr), .hdrAddr(hdrAddr),
		.wbValid(wbValid), .wbReady(wbReady), .wbWord0(wbWord0), .wbWord1(wbWord1),
		.gotW0(gotW0), .gotW1(gotW1), .gotCount(gotCount));
	// ****
	// Tasks
	// ****
	initial forever #5 clk_sys = ~clk_sys;
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= wr;
		hsel <= 1'h1;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : bus
	// Start pulses stay apart so each counts as one start
	task automatic pkt(input int n, input logic expHdr, input logic expClose);
		logic [7:0] g;
		while (bufValid !== 1'h1) @(posedge clk_sys);
		check(hdrAddrValid, expHdr);
		repeat (n) begin
			pktStart <= 1'h1;
			@(posedge clk_sys);
			pktStart <= 1'h0;
			@(posedge clk_sys);
		end
		check(coalesceClose, expClose);
		g = gotCount;
		evt <= e;
		evtValid <= 1'h1;
		do @(posedge clk_sys); while (evtReady !== 1'h1);
		evtValid <= 1'h0;
		while (gotCount === g) @(posedge clk_sys);
	endtask : pkt
	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// ****
	// Tests
	// ****
	initial begin
		#200000;
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		bus(1'h0, 32'h0, 32'h0);
		check(r, CTRL_RESET);
		bus(1'h0, 32'h40, 32'h0);
		check(r, 32'h0);
		e = '0;
		e.eop = 1'h1;
		pkt(0, 1'h1, 1'h0);
		check(gotW0, 64'h0);
		check(gotW1, 64'h3);
		for (int f = 1; f < 8; f++) begin
			bus(1'h1, 32'h0, 32'h1E08 | f);
			e = '0;
			{e.eop, e.hdrFound, e.rssCalc, e.vlanSeen, e.udp_checksum_done, e.outerIpChk} = 6'h3F;
			{e.rssType, e.ptype, e.hdrBytes, e.hash} = {4'h3, 13'h1011, 16'h40, 32'hA5A51234};
			e.innerL34 = 7'h22;
			pkt(0, 1'h1, 1'h0);
			check(gotW0, {32'hA5A51234, 1'h1, 10'h40, 4'h0, 13'h1022, 4'h3});
			check(gotW1[9:0], 10'h133);
		end
		bus(1'h1, 32'h0, 32'h1E01);
		e = '0;
		{e.coalesced, e.ipv4Frag, e.hdrFound, e.ptype, e.hdrBytes} = {3'h7, 13'h35, 16'h500};
		e.nextPtr = 16'h1234;
		pkt(2, 1'h1, 1'h0);
		check(gotW0[31:0], {1'h0, 10'h3FF, 4'h3, 13'h1, 4'h0});
		check(gotW1[19:0], {16'h1234, 4'h1});
		for (int b = 0; b < 2; b++) begin
			bus(1'h1, 32'h0, 32'h1E01 | (b << 4));
			pkt(14 + b, 1'h0, b == 0);
			check(gotW0[20:17], CNT_MAX);
		end
		bus(1'h1, 32'h0, 32'h1E41);
		e = '0;
		{e.eop, e.ipv4Frag, e.udpFragCsum, e.vlanSeen, e.fragCsum} = {4'hF, 16'hBEEF};
		e.ptype = 13'h0021;
		pkt(0, 1'h0, 1'h0);
		check({gotW0[63:48], gotW1[10], gotW1[3]}, {16'hBEEF, 1'h1, 1'h1});
		bus(1'h1, 32'h0, 32'h1801);
		e = '0;
		{e.eop, e.fdirMatch, e.rssType, e.fdirBucket, e.fdirSig} = {6'h33, 15'h7FFF, 16'h1111};
		pkt(0, 1'h1, 1'h0);
		check({gotW0[63:32], gotW1[2]}, {16'h1111, 1'h0, 15'hFFF, 1'h1});
		bus(1'h0, 32'h4, 32'h0);
		check(r[6:5], 2'h0);
		bus(1'h0, 32'h8, 32'h0);
		check(r[15:0], 16'h000D);
		finish_test;
	end
endmodule : tb_arx_desc_format
bind arx_desc_format arx_chk u_arx_chk (.clk_sys(clk_sys), .reset_n(reset_n),
	.descValid(descValid), .descReady(descReady), .pktAddr(pktAddr), .bufValid(bufValid),
	.dataAddr(dataAddr), .hdrAddrValid(hdrAddrValid), .hdrAddrOut(hdrAddrOut),
	.evtValid(evtValid), .evtReady(evtReady), .evt(evt), .wbValid(wbValid), .wbReady(wbReady),
	.wbAdvanced(wbAdvanced), .wbWord0(wbWord0), .wbWord1(wbWord1));
`default_nettype wire
